// ### rtl/glcc_ctrl.sv
// control and status registers of the glue-logic timer/counter unit
`timescale 1ns/1ps
module glcc_ctrl
   import glcc_pkg::*;
(
   // clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   // avalon-mm slave
   input  wire glcc_pkg::glcc_req_t av_req_i,
   output logic [7:0]               av_readdata_o,
   output logic                     av_waitrequest_o,
   // event channels
   input  wire logic [7:0]          event_i,
   // datapath link
   input  wire glcc_pkg::glcc_stat_t stat_i,
   output glcc_pkg::glcc_ctl_t      ctl_o,
   // waveform and pins
   input  wire logic [1:0]          wave_i,
   input  wire logic [1:0]          port_out_i,
   output logic [1:0]               pin_o,
   // interrupt requests and levels
   output logic                     underflow_irq_o,
   output logic [1:0]               underflow_irq_level_o,
   output logic                     channel_irq_o,
   output logic [1:0]               channel_irq_level_o
);
   import glcc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic [3:0] count_clock_select_reg;
   glcc_cfg_t  counter_config_select_reg;
   logic [7:0] output_and_mode_control_reg;
   logic [7:0] event_action_control_reg;
   logic [7:0] interrupt_enable_control_reg;
   logic [7:0] interrupt_flags_reg;
   logic [7:0] interrupt_flags_next;
   logic [9:0] presc_reg;
   logic [7:0] ev_prev_reg;
   logic       ack_reg;
   logic       wr_go;
   logic       strobe;
   logic       tick;
   logic       chan_ev;
   logic [7:0] ev_rise;
   logic [1:0] command_target;
   logic [1:0] mode_raw;
   glcc_mode_t mode_eff;
   logic [1:0] eva0;
   logic [1:0] eva1;
   logic       eva_en;
   logic [1:0] set_b;
   logic [1:0] set_c;
   logic [7:0] clr_w;

   function automatic logic [9:0] div_limit(input logic [2:0] code);
      case (code)
         3'h1:    div_limit = GLCC_DIV1;
         3'h2:    div_limit = GLCC_DIV2;
         3'h3:    div_limit = GLCC_DIV4;
         3'h4:    div_limit = GLCC_DIV8;
         3'h5:    div_limit = GLCC_DIV64;
         3'h6:    div_limit = GLCC_DIV256;
         3'h7:    div_limit = GLCC_DIV1024;
         default: div_limit = GLCC_DIV1;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // bus: one wait state, then ack; master holds request meanwhile
   assign wr_go = av_req_i.write & ack_reg;
   assign av_waitrequest_o = (av_req_i.read | av_req_i.write) & ~ack_reg;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (av_req_i.read | av_req_i.write) & ~ack_reg;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         av_readdata_o <= GLCC_RST_BYTE;
      end else if ((av_req_i.read) & ~ack_reg) begin
         case (av_req_i.address)
            GLCC_OFS_CLKCFG:  av_readdata_o <= {1'b0,
                  counter_config_select_reg, count_clock_select_reg};
            GLCC_OFS_OUTMODE: av_readdata_o <= output_and_mode_control_reg;
            GLCC_OFS_EVENT:   av_readdata_o <= event_action_control_reg;
            GLCC_OFS_INTEN:   av_readdata_o <= interrupt_enable_control_reg;
            GLCC_OFS_FLAGS:   av_readdata_o <= interrupt_flags_reg;
            default:          av_readdata_o <= GLCC_RST_BYTE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         count_clock_select_reg    <= GLCC_RST_NIB;
         counter_config_select_reg <= GLCC_CFG_WIDE;
      end else if (wr_go && av_req_i.address == GLCC_OFS_CLKCFG) begin
         count_clock_select_reg    <= av_req_i.writedata[3:0];
         counter_config_select_reg <=
            glcc_cfg_t'(av_req_i.writedata[6:4]);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         output_and_mode_control_reg  <= GLCC_RST_BYTE;
         event_action_control_reg     <= GLCC_RST_BYTE;
         interrupt_enable_control_reg <= GLCC_RST_BYTE;
      end else if (wr_go) begin
         if (av_req_i.address == GLCC_OFS_OUTMODE)
            output_and_mode_control_reg <= av_req_i.writedata;
         if (av_req_i.address == GLCC_OFS_EVENT)
            event_action_control_reg <= av_req_i.writedata;
         if (av_req_i.address == GLCC_OFS_INTEN)
            interrupt_enable_control_reg <= av_req_i.writedata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // count tick: prescaler or event channel, shared by both counters
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         presc_reg   <= 10'h000;
         ev_prev_reg <= GLCC_RST_BYTE;
      end else begin
         ev_prev_reg <= event_i;
         if (count_clock_select_reg == GLCC_RST_NIB || tick)
            presc_reg <= 10'h000;
         else
            presc_reg <= presc_reg + 10'h001;
      end
   end

   // events are taken as level pulses; rising edge makes one tick
   assign ev_rise = event_i & ~ev_prev_reg;

   always_comb begin
      if (count_clock_select_reg[3])
         tick = ev_rise[count_clock_select_reg[2:0]];
      else if (count_clock_select_reg == GLCC_RST_NIB)
         tick = 1'b0;
      else
         // at or above: a faster rate chosen mid-count must not stall
         tick = (presc_reg >= div_limit(count_clock_select_reg[2:0]));
   end

   ////////////////////////////////////////////////////////////////////////
   // mode, events and command
   assign command_target = output_and_mode_control_reg[7:6];
   assign mode_raw       = output_and_mode_control_reg[1:0];
   assign eva_en = event_action_control_reg[7];
   assign eva1   = event_action_control_reg[6:5];
   assign eva0   = event_action_control_reg[4:3];
   assign chan_ev = ev_rise[event_action_control_reg[2:0]];
   assign strobe = wr_go && av_req_i.address == GLCC_OFS_CLKCFG
                   && av_req_i.writedata[GLCC_STROBE_BIT];

   always_comb begin
      if (counter_config_select_reg == GLCC_CFG_DUALBC)
         mode_eff = GLCC_MODE_NORMAL;
      else
         mode_eff = glcc_mode_t'(mode_raw);
   end

   always_comb begin
      ctl_o            = '0;
      ctl_o.cfg        = counter_config_select_reg;
      ctl_o.mode       = mode_eff;
      ctl_o.tick       = tick;
      ctl_o.capt_kind0 = eva0;
      ctl_o.capt_kind1 = eva1;
      ctl_o.capt_en    = (mode_eff == GLCC_MODE_CAPTURE)
                         ? output_and_mode_control_reg[3:2] : 2'h0;
      ctl_o.restart = strobe ? command_target : 2'h0;
      if (eva_en && chan_ev) begin
         if (eva0 == GLCC_EVA_RESTART)
            ctl_o.restart[0] = 1'b1;
         if (eva1 == GLCC_EVA_RESTART)
            ctl_o.restart[1] = 1'b1;
         if (mode_eff == GLCC_MODE_CAPTURE) begin
            ctl_o.ev_capture[0] = eva0 != GLCC_EVA_RESTART;
            ctl_o.ev_capture[1] = eva1 != GLCC_EVA_RESTART;
         end
         if (mode_eff == GLCC_MODE_ONESHOT) begin
            ctl_o.stop_start[0] = eva0 == GLCC_EVA_PW;
            ctl_o.stop_start[1] = eva1 == GLCC_EVA_PW;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output pins: when enabled outside capture mode, override levels when stopped, else waveform; port value otherwise
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_o <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (mode_eff != GLCC_MODE_CAPTURE
                && output_and_mode_control_reg[2+i]) begin
               if (count_clock_select_reg == GLCC_RST_NIB)
                  pin_o[i] <= output_and_mode_control_reg[4+i];
               else
                  pin_o[i] <= wave_i[i];
            end else begin
               pin_o[i] <= port_out_i[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flags
   always_comb begin
      set_b = stat_i.bottom;
      if (counter_config_select_reg == GLCC_CFG_NIBBLES)
         set_b[1] = stat_i.nib_hi_bot;
      if (mode_eff == GLCC_MODE_CAPTURE)
         set_c = stat_i.capt_valid & output_and_mode_control_reg[3:2];
      else if (mode_eff == GLCC_MODE_NORMAL)
         set_c = stat_i.cmp_match;
      else
         set_c = 2'h0;
      if (counter_config_select_reg == GLCC_CFG_NIBBLES)
         set_c[1] = stat_i.nib_lo_bot;
      clr_w = (wr_go && av_req_i.address == GLCC_OFS_FLAGS)
              ? av_req_i.writedata : 8'h00;
      if (mode_eff == GLCC_MODE_CAPTURE)
         clr_w[5:4] = clr_w[5:4] | stat_i.capt_read;
      interrupt_flags_next = interrupt_flags_reg & ~{clr_w[7:4], 4'h0};
      interrupt_flags_next[7:6] = interrupt_flags_next[7:6] | set_b;
      interrupt_flags_next[5:4] = interrupt_flags_next[5:4] | set_c;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         interrupt_flags_reg <= GLCC_RST_BYTE;
      else
         interrupt_flags_reg <= interrupt_flags_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt requests toward the multilevel controller
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         underflow_irq_o <= 1'b0;
         channel_irq_o   <= 1'b0;
      end else begin
         underflow_irq_o <= |(interrupt_flags_reg[7:6]
                              & interrupt_enable_control_reg[7:6])
                            && interrupt_enable_control_reg[3:2] != 2'h0;
         channel_irq_o <= |(interrupt_flags_reg[5:4]
                            & interrupt_enable_control_reg[5:4])
                          && interrupt_enable_control_reg[1:0] != 2'h0;
      end
   end

   assign underflow_irq_level_o = interrupt_enable_control_reg[3:2];
   assign channel_irq_level_o   = interrupt_enable_control_reg[1:0];

endmodule // glcc_ctrl

// ### rtl/glcc_pkg.sv
// package: register map, field positions and codes of the counter control
package glcc_pkg;
   localparam logic [3:0] GLCC_OFS_CLKCFG  = 4'h4;
   localparam logic [3:0] GLCC_OFS_OUTMODE = 4'h5;
   localparam logic [3:0] GLCC_OFS_EVENT   = 4'h6;
   localparam logic [3:0] GLCC_OFS_INTEN   = 4'h7;
   localparam logic [3:0] GLCC_OFS_FLAGS   = 4'h8;
   localparam logic [7:0] GLCC_RST_BYTE  = 8'h00;
   localparam logic [3:0] GLCC_RST_NIB   = 4'h0;
   localparam int GLCC_STROBE_BIT = 7;
   localparam int GLCC_FLAG_B7 = 7;
   localparam int GLCC_FLAG_B6 = 6;
   localparam int GLCC_FLAG_B5 = 5;
   localparam int GLCC_FLAG_B4 = 4;

   typedef enum logic [2:0] {
      GLCC_CFG_WIDE    = 3'h0,
      GLCC_CFG_BYTE0   = 3'h1,
      GLCC_CFG_BYTES   = 3'h2,
      GLCC_CFG_BYTE_TX = 3'h3,
      GLCC_CFG_BYTE_RX = 3'h4,
      GLCC_CFG_DUALBC  = 3'h5,
      GLCC_CFG_NIBBLES = 3'h6,
      GLCC_CFG_RSVD    = 3'h7
   } glcc_cfg_t;

   typedef enum logic [1:0] {
      GLCC_MODE_NORMAL  = 2'h0,
      GLCC_MODE_CAPTURE = 2'h1,
      GLCC_MODE_PWM     = 2'h2,
      GLCC_MODE_ONESHOT = 2'h3
   } glcc_mode_t;

   typedef enum logic [1:0] {
      GLCC_EVA_INPUT   = 2'h0,
      GLCC_EVA_FREQ    = 2'h1,
      GLCC_EVA_PW      = 2'h2,
      GLCC_EVA_RESTART = 2'h3
   } glcc_eva_t;

   // prescaler division (minus one) for codes 1..7
   localparam logic [9:0] GLCC_DIV1    = 10'h000;
   localparam logic [9:0] GLCC_DIV2    = 10'h001;
   localparam logic [9:0] GLCC_DIV4    = 10'h003;
   localparam logic [9:0] GLCC_DIV8    = 10'h007;
   localparam logic [9:0] GLCC_DIV64   = 10'h03F;
   localparam logic [9:0] GLCC_DIV256  = 10'h0FF;
   localparam logic [9:0] GLCC_DIV1024 = 10'h3FF;

   // avalon request
   typedef struct packed {
      logic       read;
      logic       write;
      logic [3:0] address;
      logic [7:0] writedata;
   } glcc_req_t;

   // counter-facing status from the datapath
   typedef struct packed {
      logic [1:0] bottom;       // bottom of counter 0 / 1
      logic       nib_lo_bot;   // bottom of low 4-bit bit counter
      logic       nib_hi_bot;   // bottom of high 4-bit bit counter
      logic [1:0] cmp_match;    // count equals channel compare value
      logic [1:0] capt_valid;   // capture register loaded
      logic [1:0] capt_read;    // capture register read by software
      logic [1:0] running;      // counter 0 / 1 counting
   } glcc_stat_t;

   // control to the datapath
   typedef struct packed {
      glcc_cfg_t  cfg;
      glcc_mode_t mode;
      logic       tick;         // one-cycle count enable
      logic [1:0] restart;      // one-cycle restart per counter
      logic [1:0] capt_en;      // capture enabled per channel
      logic [1:0] capt_kind0;   // capture kind for counter 0
      logic [1:0] capt_kind1;   // capture kind for counter 1
      logic [1:0] ev_capture;   // capture event per counter
      logic [1:0] stop_start;   // toggle run state per counter
   } glcc_ctl_t;
endpackage

// ### tb/glcc_ctrl_sva.sv
// checker: bus timing, commands, clock, mode and pin relations
`timescale 1ns/1ps
module glcc_ctrl_sva
   import glcc_pkg::*;
(
   // clock and reset
   input wire logic                clk_i,
   input wire logic                rst_i,
   // bus
   input wire glcc_pkg::glcc_req_t av_req_i,
   input wire logic [7:0]          av_readdata_o,
   input wire logic                av_waitrequest_o,
   // events, control, pins, interrupts
   input wire logic [7:0]          event_i,
   input wire glcc_pkg::glcc_ctl_t ctl_o,
   input wire logic [1:0]          wave_i,
   input wire logic [1:0]          port_out_i,
   input wire logic [1:0]          pin_o,
   input wire logic                underflow_irq_o,
   input wire logic [1:0]          underflow_irq_level_o
);
   logic       acc;
   logic       strobe;
   logic [6:0] e_reg;
   logic [7:0] f_reg;
   logic [7:0] g_reg;
   logic [1:0] pin_exp;
   assign acc = av_req_i.write && !av_waitrequest_o;
   assign strobe = acc && av_req_i.address == GLCC_OFS_CLKCFG
                   && av_req_i.writedata[7];
   // shadow copies follow accepted writes only
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         e_reg <= 7'h00;
         f_reg <= 8'h00;
         g_reg <= 8'h00;
      end else if (acc) begin
         if (av_req_i.address == GLCC_OFS_CLKCFG)
            e_reg <= av_req_i.writedata[6:0];
         if (av_req_i.address == GLCC_OFS_OUTMODE)
            f_reg <= av_req_i.writedata;
         if (av_req_i.address == GLCC_OFS_EVENT)
            g_reg <= av_req_i.writedata;
      end
   end
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (f_reg[2+i] && ctl_o.mode != GLCC_MODE_CAPTURE)
            pin_exp[i] = (e_reg[3:0] == 4'h0) ? f_reg[4+i] : wave_i[i];
         else
            pin_exp[i] = port_out_i[i];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence req_start;
      $rose(av_req_i.read || av_req_i.write);
   endsequence
   sequence one_wait;
      av_waitrequest_o ##1 !av_waitrequest_o;
   endsequence
   one_wait_a: assert property (req_start |-> one_wait)
      else $error("wait state count wrong");
   cmd_restart_a: assert property (
      strobe |-> ctl_o.restart == f_reg[7:6])
      else $error("restart targets wrong");
   restart_src_a: assert property (
      ctl_o.restart[0] |-> (strobe && f_reg[6])
      || (g_reg[7] && g_reg[4:3] == 2'h3))
      else $error("restart without cause");
   strobe_zero_a: assert property (
      av_req_i.read && !av_waitrequest_o
      && av_req_i.address == GLCC_OFS_CLKCFG |-> !av_readdata_o[7])
      else $error("strobe bit read as one");
   div1_tick_a: assert property (
      e_reg[3:0] == 4'h1 && $past(e_reg[3:0]) == 4'h1 |-> ctl_o.tick)
      else $error("missing tick at full rate");
   off_tick_a: assert property (
      e_reg[3:0] == 4'h0 && $past(e_reg[3:0]) == 4'h0 |-> !ctl_o.tick)
      else $error("tick while stopped");
   ev_tick_a: assert property (
      e_reg[3] && $stable(e_reg) && $rose(event_i[e_reg[2:0]])
      |-> ##[0:1] ctl_o.tick)
      else $error("event channel gave no tick");
   cfg_mode_a: assert property (
      ctl_o.cfg == e_reg[6:4] && ctl_o.mode ==
      ((e_reg[6:4] == 3'h5) ? 2'h0 : f_reg[1:0]))
      else $error("configuration or mode wrong");
   // the edge that releases reset still clocks pins under reset
   pin_a: assert property (
      !$past(rst_i) |-> pin_o == $past(pin_exp))
      else $error("pin level wrong");
   irq_lvl_a: assert property (
      underflow_irq_o |-> $past(underflow_irq_level_o) != 2'h0)
      else $error("interrupt with level zero");
endmodule // glcc_ctrl_sva
bind glcc_ctrl glcc_ctrl_sva i_glcc_ctrl_sva (.clk_i(clk_i), .rst_i(rst_i),
   .av_req_i(av_req_i), .av_readdata_o(av_readdata_o),
   .av_waitrequest_o(av_waitrequest_o), .event_i(event_i), .ctl_o(ctl_o),
   .wave_i(wave_i), .port_out_i(port_out_i), .pin_o(pin_o),
   .underflow_irq_o(underflow_irq_o),
   .underflow_irq_level_o(underflow_irq_level_o));

// ### tb/glcc_dp_model.sv
// datapath stand-in: down counter giving bottom and match pulses
`timescale 1ns/1ps
module glcc_dp_model
   import glcc_pkg::*;
#(parameter logic [7:0] PER = 8'h03)
(
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // control in, status out
   input  wire glcc_pkg::glcc_ctl_t  ctl_i,
   input  wire glcc_pkg::glcc_stat_t force_i,
   output glcc_pkg::glcc_stat_t      stat_o
);
   logic [7:0] cnt_reg;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         cnt_reg <= PER;
      else if (ctl_i.restart[0] || (ctl_i.tick && cnt_reg == 8'h00))
         cnt_reg <= PER;
      else if (ctl_i.tick)
         cnt_reg <= cnt_reg - 8'h01;
   end
   // bench pulses are merged so rare sources need no real counters
   always_comb begin
      stat_o = force_i;
      stat_o.bottom[0] = force_i.bottom[0] | (ctl_i.tick && cnt_reg == 8'h00);
      stat_o.cmp_match[0] = force_i.cmp_match[0]
                            | (ctl_i.tick && cnt_reg == 8'h01);
   end
endmodule // glcc_dp_model

// ### tb/test_glue_logic_counter_control.sv
// testbench: registers, commands, clocks, events, flags and pins
`timescale 1ns/1ps
module test_glue_logic_counter_control;
   import glcc_pkg::*;
   logic       clk_i;
   logic       rst_i;
   glcc_req_t  av_req;
   glcc_stat_t stat;
   glcc_stat_t force_r;
   glcc_ctl_t  ctl;
   logic [7:0] rdata;
   logic [7:0] event_r;
   logic [7:0] q;
   logic [1:0] wave_r;
   logic [1:0] port_r;
   logic [1:0] pin;
   logic [1:0] unf_lvl;
   logic [1:0] ch_lvl;
   logic [1:0] rs_seen;
   logic       waitr;
   logic       unf_irq;
   logic       ch_irq;
   int         bad_count;
   int         compares;
   int         tick_n;
   int         rst_n;
   int         ss_n;
   int         cap_n;
   int         n0;
   glcc_ctrl i_glcc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .av_req_i(av_req),
      .av_readdata_o(rdata), .av_waitrequest_o(waitr), .event_i(event_r),
      .stat_i(stat), .ctl_o(ctl), .wave_i(wave_r), .port_out_i(port_r),
      .pin_o(pin), .underflow_irq_o(unf_irq), .underflow_irq_level_o(unf_lvl),
      .channel_irq_o(ch_irq), .channel_irq_level_o(ch_lvl));
   glcc_dp_model i_glcc_dp_model (.clk_i(clk_i), .rst_i(rst_i), .ctl_i(ctl),
      .force_i(force_r), .stat_o(stat));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // counted at the falling edge, where the pulses are settled
   always @(negedge clk_i) begin
      tick_n += (ctl.tick === 1'b1);
      rst_n += (ctl.restart[0] === 1'b1);
      ss_n += (ctl.stop_start[0] === 1'b1);
      cap_n += (ctl.ev_capture[0] === 1'b1);
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkn(input int got, input int exp);
      compares++;
      if (got != exp) begin
         bad_count++;
         $display("BAD %0t count %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [7:0] d);
      @(posedge clk_i);
      av_req <= '{read: !wr, write: wr, address: a, writedata: d};
      // answer, read data and restart pulse are all taken at the edge
      do begin
         @(posedge clk_i);
         q = rdata;
         rs_seen = ctl.restart;
      end while (waitr !== 1'b0);
      av_req <= '0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk(q, exp);
   endtask
   task automatic evp(input int ch);
      @(posedge clk_i);
      event_r[ch] <= 1'b1;
      @(posedge clk_i);
      event_r <= 8'h00;
   endtask
   // field order: bottom, nibble lo, nibble hi, match, valid, read, run
   task automatic sp(input logic [11:0] s);
      @(posedge clk_i);
      force_r <= s;
      @(posedge clk_i);
      force_r <= '0;
   endtask
   task automatic pinchk(input logic [3:0] a, input logic [7:0] d,
                         input logic [1:0] exp);
      wr(a, d);
      repeat (2) @(negedge clk_i);
      chk({6'h00, pin}, {6'h00, exp});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      for (int a = 4; a < 9; a++)
         rdchk(4'(a), GLCC_RST_BYTE);
      wr(4'hF, 8'hFF);
      rdchk(4'hF, 8'h00);
      wr(4'h5, 8'h3C);
      rdchk(4'h5, 8'h3C);
      wr(4'h6, 8'h5A);
      rdchk(4'h6, 8'h5A);
      wr(4'h4, 8'hE1);
      rdchk(4'h4, 8'h61);
      for (int c = 0; c < 7; c++) begin
         wr(4'h4, {1'b0, 3'(c), 4'h0});
         @(negedge clk_i);
         chk(8'(ctl.cfg), 8'(c));
      end
   endtask
   task automatic t_cmd();
      for (int t = 0; t < 4; t++) begin
         wr(4'h5, {2'(t), 6'h00});
         wr(4'h4, 8'h81);
         chk(8'(rs_seen), 8'(t));
      end
      wr(4'h4, 8'h01);
      chk(8'(rs_seen), 8'h00);
   endtask
   task automatic t_clock();
      int dv[8] = '{0, 1, 2, 4, 8, 64, 256, 1024};
      for (int c = 0; c < 8; c++) begin
         wr(4'h4, 8'(c));
         n0 = tick_n;
         repeat (2048) @(posedge clk_i);
         chkn(tick_n - n0, (c == 0) ? 0 : 2048 / dv[c]);
      end
      for (int ch = 0; ch < 8; ch++) begin
         wr(4'h4, 8'(8 + ch));
         n0 = tick_n;
         evp(ch);
         evp(ch ^ 1);
         repeat (2) @(posedge clk_i);
         chkn(tick_n - n0, 1);
      end
   endtask
   task automatic t_evact();
      wr(4'h4, 8'h00);
      wr(4'h6, 8'h9A);
      n0 = rst_n;
      evp(2);
      evp(5);
      wr(4'h6, 8'h1A);
      evp(2);
      chkn(rst_n - n0, 1);
      wr(4'h5, 8'h03);
      wr(4'h6, 8'h8A);
      n0 = ss_n;
      evp(2);
      wr(4'h6, 8'h92);
      evp(2);
      repeat (2) @(posedge clk_i);
      chkn(ss_n - n0, 1);
      wr(4'h5, 8'h01);
      wr(4'h6, 8'h8A);
      @(negedge clk_i);
      chk(8'(ctl.capt_kind0), 8'h01);
      n0 = cap_n;
      evp(2);
      repeat (2) @(posedge clk_i);
      chkn(cap_n - n0, 1);
   endtask
   task automatic t_flags();
      wr(4'h5, 8'h00);
      wr(4'h7, 8'h54);
      wr(4'h4, 8'h01);
      repeat (10) @(posedge clk_i);
      wr(4'h4, 8'h00);
      rdchk(4'h8, 8'h50);
      chk({6'h00, unf_irq, ch_irq}, 8'h02);
      chk({4'h0, unf_lvl, ch_lvl}, 8'h04);
      wr(4'h8, 8'h50);
      rdchk(4'h8, 8'h00);
      wr(4'h5, 8'h0D);
      sp(12'h020);
      rdchk(4'h8, 8'h20);
      sp(12'h008);
      rdchk(4'h8, 8'h00);
      wr(4'h4, 8'h60);
      sp(12'h300);
      rdchk(4'h8, 8'hA0);
      wr(4'h8, 8'hA0);
      rdchk(4'h8, 8'h00);
      wr(4'h4, 8'h50);
      wr(4'h5, 8'h02);
      @(negedge clk_i);
      chk(8'(ctl.mode), 8'h00);
      sp(12'hC00);
      rdchk(4'h8, 8'hC0);
      // bottom pulse lands in the accept cycle of the clearing write
      fork
         wr(4'h8, 8'hC0);
         begin
            @(posedge clk_i);
            sp(12'hC00);
         end
      join
      rdchk(4'h8, 8'hC0);
   endtask
   task automatic t_pins();
      wr(4'h4, 8'h00);
      pinchk(4'h5, 8'h14, 2'b11);
      pinchk(4'h5, 8'h04, 2'b10);
      pinchk(4'h4, 8'h01, 2'b11);
      pinchk(4'h5, 8'h05, 2'b10);
      chk(8'(ctl.capt_en), 8'h01);
   endtask
   task automatic final_report();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_i = 1'b1;
      av_req = '0;
      force_r = '0;
      event_r = 8'h00;
      wave_r = 2'b11;
      port_r = 2'b10;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_cmd();
      t_clock();
      t_evact();
      t_flags();
      t_pins();
      final_report();
   end
   // the sweep of clock codes dominates, about 17000 cycles
   initial begin
      #1000000;
      bad_count++;
      final_report();
   end
endmodule // test_glue_logic_counter_control
